// file: include/spx_cfg.svh
/*
 Constants of the serial port expander controller: rates, timing counts,
 register offsets, field positions and reset values.
 Assumes the includer wants plain text macros; holds definitions only.
*/
`ifndef SPX_CFG_SVH
`define SPX_CFG_SVH

// ==========================================
// Clock and transfer timing
`define SPX_SYS_HZ        100000000
`define SPX_SCK_HZ        1562500
`define SPX_SCK_MAX_HZ    1923000
`define SPX_SCK_HALF_CYC  (`SPX_SYS_HZ / (2 * `SPX_SCK_HZ))
`define SPX_SCK_MIN_HALF  ((`SPX_SYS_HZ + 2 * `SPX_SCK_MAX_HZ - 1) / (2 * `SPX_SCK_MAX_HZ))

// ==========================================
// Frame shape
`define SPX_BYTES         3
`define SPX_FIFO_DEPTH    2

// ==========================================
// Register map (byte addresses) and fields
`define SPX_OFS_CTRL      4'h0
`define SPX_OFS_TXDATA    4'h4
`define SPX_OFS_RXDATA    4'h8
`define SPX_OFS_STATUS    4'hC
`define SPX_CTRL_EN_BIT   0
`define SPX_ST_BUSY_BIT   0
`define SPX_ST_FULL_BIT   1
`define SPX_ST_EMPTY_BIT  2
`define SPX_ST_DONE_BIT   3
`define SPX_CTRL_EN_RST   1'h0
`define SPX_RESP_OKAY     2'h0
`define SPX_RESP_SLVERR   2'h2

`endif

// file: include/spx_pkg.sv
/*
 Types of the serial port expander controller: FSM states, AXI4-Lite
 channel bundles and the expander pin bundle.
 Needs nothing from spx_cfg.svh; state codes and field widths are written here.
*/
package spx_pkg;

	// ==========================================
	// Sequencer states
	typedef enum logic [5:0] {
		spx_st_idle    = 6'h01,
		spx_st_float   = 6'h02,
		spx_st_recover = 6'h04,
		spx_st_select  = 6'h08,
		spx_st_shift   = 6'h10,
		spx_st_finish  = 6'h20
	} spx_state_t;

	// ==========================================
	// AXI4-Lite bundles, 4-bit byte address
	typedef struct packed {
		logic        awvalid;
		logic [3:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [3:0]  araddr;
		logic        rready;
	} spx_axil_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} spx_axil_rsp_t;

	// ==========================================
	// Expander pins
	typedef struct packed {
		logic sck;
		logic txd;
		logic float_strobe_line_n;
		logic transfer_select_line_n;
	} spx_pins_t;

endpackage

// file: logic/spx_ctrl.sv
/*
 Serial port expander controller: AXI4-Lite register slave, two-entry word
 buffer and a sequencer that runs one 24-bit full-duplex frame per word.
 Assumes one 100 MHz clock, synchronous active-low reset, and an expander
 that floats its ports while the float strobe is low.
*/
// Behaviour
// - Transfer clock never exceeds 1.923 MHz.
// - Clock-synchronous channel, transmitter and receiver both active each frame.
// - Transfer clock generated internally at 1.5625 MHz.
// - Every byte shifted least significant bit first, both directions.
// - Three 8-bit full-duplex exchanges per update, 24 bits in total.
// - Float strobe pulses low then high before a transfer; expander floats meanwhile.
// - Select goes low after strobe, 24 bits move, then select goes high.
`timescale 1ns/10ps
`include "spx_cfg.svh"

module spx_ctrl #(
	parameter int BYTES  = `SPX_BYTES,
	parameter int DEPTH  = `SPX_FIFO_DEPTH,
	parameter int HALF   = `SPX_SCK_HALF_CYC,
	parameter int STROBE = `SPX_SCK_HALF_CYC
) (
	input  logic                   aclk,
	input  logic                   aresetn,
	input  spx_pkg::spx_axil_req_t axi_req,
	output spx_pkg::spx_axil_rsp_t axi_rsp,
	input  logic                   rxd_pin,
	output spx_pkg::spx_pins_t     pins
);
	import spx_pkg::*;

	localparam int W  = 8 * BYTES;
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(W + 1);
	localparam int TW = 16;
	localparam logic [TW-1:0] HALF_LD = TW'(HALF - 1);
	localparam logic [TW-1:0] STB_LD  = TW'(STROBE - 1);
	localparam logic [CW-1:0] W_CNT   = CW'(W);

	// ==========================================
	// Elaboration checks
	if (BYTES < 1 || BYTES > 4 || DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 ||
	    HALF < `SPX_SCK_MIN_HALF || HALF > 65535 || STROBE < 1 || STROBE > 65535) begin : g_chk
		$error("spx_ctrl: unsupported parameter values");
	end

	// ==========================================
	// State
	typedef struct packed {
		spx_state_t              st;
		logic [TW-1:0]           tmr;
		logic [CW-1:0]           bits;
		logic [W-1:0]            sh;
		logic [W-1:0]            cur;
		logic [W-1:0]            rsh;
		logic [W-1:0]            rx;
		logic                    s1;
		logic                    s2;
		logic                    s3;
		logic                    rxf;
		logic [DEPTH-1:0][W-1:0] mem;
		logic [PW:0]             wp;
		logic [PW:0]             rp;
		logic                    en;
		logic                    done;
		logic [W-1:0]            stage;
		logic [3:0]              awa;
		logic                    awg;
		logic                    wg;
		logic [31:0]             wd;
		logic [3:0]              ws;
		spx_axil_rsp_t           rsp;
		spx_pins_t               pin;
		logic [TW-1:0]           hold;
	} spx_ctrl_state_t;

	function automatic spx_ctrl_state_t rst_val();
		spx_ctrl_state_t v;
		v             = '0;
		v.st          = spx_st_idle;
		v.pin         = '1;
		v.s1          = 1'h1;
		v.s2          = 1'h1;
		v.s3          = 1'h1;
		v.rxf         = 1'h1;
		v.en          = `SPX_CTRL_EN_RST;
		v.rsp.awready = 1'h1;
		v.rsp.wready  = 1'h1;
		v.rsp.arready = 1'h1;
		v.hold        = '1;
		return v;
	endfunction

	// Byte-lane merge of a write into an existing value
	function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] d, logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[8*i +: 8] = d[8*i +: 8];
			end
		end
		return r;
	endfunction

	spx_ctrl_state_t q_ff;
	spx_ctrl_state_t nxt_q;
	logic            f_full;
	logic            f_empty;
	logic            tick;
	logic            pop;
	logic            set_done;
	logic            clr_done;
	logic [31:0]     wv;
	logic [31:0]     rv;

	// ==========================================
	// Next state
	always_comb begin
		nxt_q    = q_ff;
		set_done = 1'h0;
		clr_done = 1'h0;
		wv       = 32'h0;
		rv       = 32'h0;

		// Pin synchroniser; the filtered level moves only when stages two and three agree
		nxt_q.s1 = rxd_pin;
		nxt_q.s2 = q_ff.s1;
		nxt_q.s3 = q_ff.s2;
		if (q_ff.s2 == q_ff.s3) begin
			nxt_q.rxf = q_ff.s3;
		end

		f_empty = (q_ff.wp == q_ff.rp);
		f_full  = (q_ff.wp[PW] != q_ff.rp[PW]) && (q_ff.wp[PW-1:0] == q_ff.rp[PW-1:0]);
		tick    = (q_ff.tmr == '0);
		if (!tick) begin
			nxt_q.tmr = q_ff.tmr - TW'(1);
		end
		// Drain side of the buffer: ready only while idle and enabled
		pop = (q_ff.st == spx_st_idle) && q_ff.en && !f_empty;

		unique case (q_ff.st)
			spx_st_idle: begin
				if (pop) begin
					nxt_q.cur                     = q_ff.mem[q_ff.rp[PW-1:0]];
					nxt_q.sh                      = q_ff.mem[q_ff.rp[PW-1:0]];
					nxt_q.rp                      = q_ff.rp + (PW+1)'(1);
					nxt_q.pin.float_strobe_line_n = 1'h0;
					nxt_q.tmr                     = STB_LD;
					nxt_q.st                      = spx_st_float;
				end
			end
			spx_st_float: begin
				if (tick) begin
					nxt_q.pin.float_strobe_line_n = 1'h1;
					nxt_q.tmr                     = STB_LD;
					nxt_q.st                      = spx_st_recover;
				end
			end
			spx_st_recover: begin
				if (tick) begin
					nxt_q.pin.transfer_select_line_n = 1'h0;
					nxt_q.tmr                        = HALF_LD;
					nxt_q.bits                       = '0;
					nxt_q.st                         = spx_st_select;
				end
			end
			spx_st_select: begin
				if (tick) begin
					nxt_q.pin.sck = 1'h0;
					nxt_q.pin.txd = q_ff.sh[0];
					nxt_q.tmr     = HALF_LD;
					nxt_q.st      = spx_st_shift;
				end
			end
			spx_st_shift: begin
				if (tick) begin
					nxt_q.tmr = HALF_LD;
					if (!q_ff.pin.sck) begin
						// Rising edge: sample receive, advance both shifters
						nxt_q.pin.sck = 1'h1;
						nxt_q.rsh     = {q_ff.rxf, q_ff.rsh[W-1:1]};
						nxt_q.sh      = q_ff.sh >> 1;
						nxt_q.bits    = q_ff.bits + CW'(1);
						if (q_ff.bits + CW'(1) == W_CNT) begin
							nxt_q.st = spx_st_finish;
						end
					end else begin
						nxt_q.pin.sck = 1'h0;
						nxt_q.pin.txd = q_ff.sh[0];
					end
				end
			end
			spx_st_finish: begin
				if (tick) begin
					nxt_q.pin.transfer_select_line_n = 1'h1;
					nxt_q.rx                         = q_ff.rsh;
					set_done                         = 1'h1;
					nxt_q.st                         = spx_st_idle;
				end
			end
		endcase

		// Write channels are taken independently, one write in flight
		if (axi_req.awvalid && q_ff.rsp.awready) begin
			nxt_q.awa = axi_req.awaddr;
			nxt_q.awg = 1'h1;
		end
		if (axi_req.wvalid && q_ff.rsp.wready) begin
			nxt_q.wd  = axi_req.wdata;
			nxt_q.ws  = axi_req.wstrb;
			nxt_q.wg  = 1'h1;
		end
		if (q_ff.awg && q_ff.wg && !q_ff.rsp.bvalid) begin
			nxt_q.rsp.bresp = `SPX_RESP_OKAY;
			nxt_q.rsp.bvalid = 1'h1;
			case (q_ff.awa)
				`SPX_OFS_CTRL: begin
					wv       = merge({31'h0, q_ff.en}, q_ff.wd, q_ff.ws);
					nxt_q.en = wv[`SPX_CTRL_EN_BIT];
				end
				`SPX_OFS_TXDATA: begin
					// A full buffer holds the response back, stalling the master
					wv = merge(32'(q_ff.stage), q_ff.wd, q_ff.ws);
					if (f_full) begin
						nxt_q.rsp.bvalid = 1'h0;
					end else begin
						nxt_q.stage                  = wv[W-1:0];
						nxt_q.mem[q_ff.wp[PW-1:0]]   = wv[W-1:0];
						nxt_q.wp                     = q_ff.wp + (PW+1)'(1);
					end
				end
				`SPX_OFS_STATUS: begin
					clr_done = q_ff.ws[0] && q_ff.wd[`SPX_ST_DONE_BIT];
				end
				`SPX_OFS_RXDATA: begin
				end
				default: begin
					nxt_q.rsp.bresp = `SPX_RESP_SLVERR;
				end
			endcase
		end
		if (q_ff.rsp.bvalid && axi_req.bready) begin
			nxt_q.rsp.bvalid = 1'h0;
			nxt_q.awg        = 1'h0;
			nxt_q.wg         = 1'h0;
		end
		nxt_q.rsp.awready = !nxt_q.awg;
		nxt_q.rsp.wready  = !nxt_q.wg;
		// Completion wins over a clear in the same cycle
		nxt_q.done = set_done | (q_ff.done & ~clr_done);

		// Read channel: data captured when the address is taken
		if (axi_req.arvalid && q_ff.rsp.arready) begin
			nxt_q.rsp.rresp = `SPX_RESP_OKAY;
			case (axi_req.araddr)
				`SPX_OFS_CTRL:   rv = {31'h0, q_ff.en};
				`SPX_OFS_TXDATA: rv = 32'(q_ff.stage);
				`SPX_OFS_RXDATA: rv = 32'(q_ff.rx);
				`SPX_OFS_STATUS: begin
					rv[`SPX_ST_BUSY_BIT]  = (q_ff.st != spx_st_idle);
					rv[`SPX_ST_FULL_BIT]  = f_full;
					rv[`SPX_ST_EMPTY_BIT] = f_empty;
					rv[`SPX_ST_DONE_BIT]  = q_ff.done;
				end
				default: nxt_q.rsp.rresp = `SPX_RESP_SLVERR;
			endcase
			nxt_q.rsp.rdata   = rv;
			nxt_q.rsp.rvalid  = 1'h1;
			nxt_q.rsp.arready = 1'h0;
		end
		if (q_ff.rsp.rvalid && axi_req.rready) begin
			nxt_q.rsp.rvalid  = 1'h0;
			nxt_q.rsp.arready = 1'h1;
		end

		// Cycles since the transfer clock last moved, saturating
		if (nxt_q.pin.sck != q_ff.pin.sck) begin
			nxt_q.hold = '0;
		end else if (q_ff.hold != '1) begin
			nxt_q.hold = q_ff.hold + TW'(1);
		end

		if (!aresetn) begin
			nxt_q = rst_val();
		end
	end

	always_ff @(posedge aclk) begin
		q_ff <= nxt_q;
	end

	assign axi_rsp = q_ff.rsp;
	assign pins    = q_ff.pin;

	// ==========================================
	// Checks
	localparam int HALF_I = HALF;
	localparam int STB_I  = STROBE;
	localparam int MIN_I  = `SPX_SCK_MIN_HALF;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_SCK_MAX: assert property ($changed(pins.sck) |-> $past(q_ff.hold) >= TW'(MIN_I - 1))
		else $error("transfer clock half period too short");
	AST_SCK_RATE: assert property ($fell(pins.sck) |-> ##HALF_I $rose(pins.sck))
		else $error("transfer clock low phase wrong length");
	AST_TXD_ON_FALL: assert property ($changed(pins.txd) |-> $fell(pins.sck))
		else $error("transmit data moved off the falling edge");
	AST_LSB_FIRST: assert property ($fell(pins.sck) |-> pins.txd == q_ff.cur[q_ff.bits])
		else $error("transmit bit order wrong");
	AST_RX_SAMPLE: assert property ($rose(pins.sck) |-> q_ff.rsh[W-1] == $past(q_ff.rxf))
		else $error("receive bit not sampled at rising edge");
	AST_BIT_COUNT: assert property ($rose(pins.transfer_select_line_n) |-> q_ff.bits == W_CNT)
		else $error("frame did not carry all bits");
	AST_RX_RESULT: assert property ($rose(pins.transfer_select_line_n) |-> q_ff.rx == q_ff.rsh)
		else $error("received word not stored at frame end");
	AST_FLOAT_PULSE: assert property ($fell(pins.float_strobe_line_n) |->
		##STB_I $rose(pins.float_strobe_line_n))
		else $error("float strobe low phase wrong length");
	AST_SEL_AFTER_FLOAT: assert property ($fell(pins.transfer_select_line_n) |->
		pins.float_strobe_line_n && $past(q_ff.st) == spx_st_recover)
		else $error("select fell without a preceding float strobe");
	AST_SCK_IDLE: assert property (pins.transfer_select_line_n |-> pins.sck)
		else $error("transfer clock moved outside the frame");
	AST_BUS_STALL: assert property (q_ff.awg && q_ff.wg && !q_ff.rsp.bvalid &&
		q_ff.awa == `SPX_OFS_TXDATA && f_full |=> !q_ff.rsp.bvalid)
		else $error("write accepted into a full buffer");

	COV_FRAME: cover property ($rose(pins.transfer_select_line_n));
	COV_FULL: cover property (f_full);
	COV_BACK2BACK: cover property ($rose(pins.transfer_select_line_n) ##[1:200]
		$fell(pins.float_strobe_line_n));
	COV_READ: cover property (q_ff.rsp.rvalid && axi_req.rready);

endmodule

// file: test/spx_expander.sv
/*
 Behavioural serial-in parallel-out port expander that sits on the far side of the controller.
 Assumes sck idles high, the pins come from flops, and one response word is offered per frame.
*/
`timescale 1ns/10ps

module spx_expander (
	input  spx_pkg::spx_pins_t pins,
	input  logic [23:0]        resp,
	output logic               rxd,
	output logic [23:0]        got_word,
	output int                 got_cnt,
	output int                 got_bits,
	output int                 order_err
);
	import spx_pkg::*;
	logic        floated;
	logic        in_frame;
	logic        ports_float;
	logic [23:0] sh_in;
	logic [23:0] sh_out;
	int          nb;

	initial begin
		{rxd, floated, in_frame, got_word, sh_in, sh_out} = '0;
		{got_cnt, got_bits, order_err, nb} = '0;
	end

	// ==========================================
	// Framing
	// Only the float state is modelled; the expanded ports themselves are not
	assign ports_float = !pins.float_strobe_line_n;
	always @(negedge pins.float_strobe_line_n) floated = 1'h1;
	always @(negedge pins.transfer_select_line_n) begin
		if (!floated || ports_float) order_err++;
		floated = 1'h0;
		in_frame = 1'h1;
		nb = 0;
		sh_out = resp;
		rxd = resp[0];
	end
	// Only a rise that closes an opened frame counts; the first reset edge is no frame end
	always @(posedge pins.transfer_select_line_n) begin
		if (in_frame) begin
			in_frame = 1'h0;
			got_word = sh_in;
			got_bits = nb;
			// Released line shows the inverse so a stale bit cannot pass by luck
			rxd = ~rxd;
			got_cnt++;
		end
	end

	// ==========================================
	// Shifting: capture on rise, launch on fall
	always @(posedge pins.sck) begin
		if (pins.transfer_select_line_n === 1'h0) begin
			sh_in = {pins.txd, sh_in[23:1]};
			nb++;
		end
	end
	always @(negedge pins.sck) begin
		if (pins.transfer_select_line_n === 1'h0 && nb < 24) rxd = sh_out[nb];
	end
endmodule

// file: test/spx_ctrl_bench.sv
/*
 Self-checking bench of the expander controller: AXI4-Lite master tasks, word-level reference
 model and the expander partner. Assumes spx_pkg, spx_cfg.svh and spx_expander compiled first.
*/
`timescale 1ns/10ps
`include "spx_cfg.svh"

module spx_ctrl_bench;
	import spx_pkg::*;
	localparam int HALF = 32;
	localparam int STROBE = 4;
	logic          aclk;
	logic          aresetn;
	logic          rxd;
	logic          prev_sck;
	logic          seen;
	spx_axil_req_t req;
	spx_axil_rsp_t rsp;
	spx_pins_t     pins;
	logic [23:0]   resp;
	logic [23:0]   got_word;
	logic [23:0]   rsp_arr [8];
	logic [23:0]   exp_q [$];
	logic [31:0]   rd_d;
	logic [31:0]   w;
	logic [1:0]    rd_r;
	int            got_cnt;
	int            got_bits;
	int            order_err;
	int            bad_count;
	int            n_tests;
	int            cyc;
	int            gap;
	int            seed;

	spx_ctrl #(.HALF(HALF), .STROBE(STROBE)) i_spx_ctrl (.aclk(aclk), .aresetn(aresetn),
		.axi_req(req), .axi_rsp(rsp), .rxd_pin(rxd), .pins(pins));
	spx_expander i_spx_expander (.pins(pins), .resp(resp), .rxd(rxd), .got_word(got_word),
		.got_cnt(got_cnt), .got_bits(got_bits), .order_err(order_err));

	always #5 aclk = ~aclk;

	// ==========================================
	// Checking and closing
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic end_sim();
		if (bad_count == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// ==========================================
	// AXI4-Lite master
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
		@(posedge aclk);
		req.awvalid <= 1'h1;
		req.awaddr <= a;
		req.wvalid <= 1'h1;
		req.wdata <= d;
		req.bready <= 1'h1;
		forever begin
			@(posedge aclk);
			if (req.awvalid && rsp.awready) req.awvalid <= 1'h0;
			if (req.wvalid && rsp.wready) req.wvalid <= 1'h0;
			if (rsp.bvalid === 1'h1) begin
				req.bready <= 1'h0;
				chk({30'h0, rsp.bresp}, {30'h0, e});
				break;
			end
		end
	endtask

	task automatic rd(input logic [3:0] a);
		@(posedge aclk);
		req.arvalid <= 1'h1;
		req.araddr <= a;
		req.rready <= 1'h1;
		forever begin
			@(posedge aclk);
			if (req.arvalid && rsp.arready) req.arvalid <= 1'h0;
			if (rsp.rvalid === 1'h1) begin
				rd_d = rsp.rdata;
				rd_r = rsp.rresp;
				req.rready <= 1'h0;
				break;
			end
		end
	endtask

	task automatic rchk(input logic [3:0] a, input logic [31:0] e);
		rd(a);
		chk({30'h0, rd_r}, {30'h0, `SPX_RESP_OKAY});
		chk(rd_d, e);
	endtask

	task automatic wait_done();
		do rd(`SPX_OFS_STATUS); while (rd_d[`SPX_ST_DONE_BIT] !== 1'h1);
	endtask

	// ==========================================
	// Reference comparisons on the wire
	always @(got_cnt) begin
		if (got_cnt > 0) begin
			chk({8'h0, got_word}, {8'h0, exp_q.pop_front()});
			chk(32'(got_bits), 32'h18);
		end
	end

	always @(posedge aclk) begin
		resp <= rsp_arr[got_cnt[2:0]];
		prev_sck <= pins.sck;
		gap <= gap + 1;
		cyc <= cyc + 1;
		if (pins.transfer_select_line_n) seen <= 1'h0;
		if (pins.sck && !prev_sck && !pins.transfer_select_line_n) begin
			if (seen) chk(32'(gap), 32'(2 * HALF));
			gap <= 1;
			seen <= 1'h1;
		end
		if (cyc == 30000) begin
			bad_count++;
			end_sim();
		end
	end

	// ==========================================
	// Main sequence
	initial begin
		{aclk, aresetn, prev_sck, seen} = '0;
		req = '0;
		req.wstrb = 4'hF;
		resp = '0;
		{bad_count, n_tests, cyc, gap} = '0;
		seed = 79;
		for (int i = 0; i < 8; i++) rsp_arr[i] = 24'($random(seed));
		repeat (20) @(posedge aclk);
		aresetn <= 1'h1;
		rchk(`SPX_OFS_CTRL, 32'h0);
		rchk(`SPX_OFS_STATUS, 32'h4);
		wr(4'h6, 32'h1, `SPX_RESP_SLVERR);
		rd(4'h6);
		chk({30'h0, rd_r}, {30'h0, `SPX_RESP_SLVERR});
		// Two words wait while disabled; once enabled a third refills the buffer and a
		// fourth is held off by the withheld write response until the first frame ends
		for (int i = 0; i < 4; i++) begin
			if (i == 2) begin
				rchk(`SPX_OFS_STATUS, 32'h2);
				chk(32'(got_cnt), 32'h0);
				wr(`SPX_OFS_CTRL, 32'h1, `SPX_RESP_OKAY);
			end
			if (i == 3) rchk(`SPX_OFS_STATUS, 32'h3);
			w = $random(seed);
			exp_q.push_back(w[23:0]);
			wr(`SPX_OFS_TXDATA, w, `SPX_RESP_OKAY);
		end
		while (got_cnt < 4) @(posedge aclk);
		wait_done();
		chk(rd_d, 32'hC);
		rchk(`SPX_OFS_RXDATA, {8'h0, rsp_arr[3]});
		chk(32'(order_err), 32'h0);
		// One frame per word, received word read back each time
		for (int k = 4; k < 7; k++) begin
			wr(`SPX_OFS_STATUS, 32'h8, `SPX_RESP_OKAY);
			rchk(`SPX_OFS_STATUS, 32'h4);
			w = $random(seed);
			exp_q.push_back(w[23:0]);
			wr(`SPX_OFS_TXDATA, w, `SPX_RESP_OKAY);
			rchk(`SPX_OFS_TXDATA, {8'h0, w[23:0]});
			wait_done();
			rchk(`SPX_OFS_RXDATA, {8'h0, rsp_arr[k]});
		end
		wr(`SPX_OFS_RXDATA, 32'h0, `SPX_RESP_OKAY);
		rchk(`SPX_OFS_RXDATA, {8'h0, rsp_arr[6]});
		// Lane 0 masked off: the enable bit must keep its value
		req.wstrb <= 4'hE;
		wr(`SPX_OFS_CTRL, 32'h0, `SPX_RESP_OKAY);
		req.wstrb <= 4'hF;
		rchk(`SPX_OFS_CTRL, 32'h1);
		chk(32'(order_err), 32'h0);
		end_sim();
	end
endmodule
